/* File: rtl/link_recovery_pkg.sv */
// Shared types, register map and timing constants for the link recovery block
//
// Operation
// - Retransmission count goes to zero on UA, RNR or an N(R) that advances.
// - T1 expiry enters timer recovery, counts one more try, latches V(S) into x.
// - T1 expiry restarts T1, rewinds V(S) to last N(R), resends with P set.
// - In recovery, S frame with F=1 and N(R) in V(S)..x ends recovery, V(S)=N(R).
// - In recovery, S frame with F=0 in range updates V(S) but keeps recovery.
// - Count reaching N2 starts a reset of the outgoing direction.
// - SABM is answered with UA at once, zeroes V(S) and V(R), clears busy.
// - A DM sent to ask for reset puts the device in the disconnected phase.
// - After FRMR, only SABM, DISC or a DM response leave frame rejection.
// - Other commands in frame rejection resend FRMR with identical information.
// - FRMR starts T1; expiry resends FRMR; after N2 sends reset by SABM.
// - Unknown frame, bad information or bad N(R) in transfer triggers FRMR.
// - FRMR bit 13 is 0 for address B, 1 for address A.
// - A DM or FRMR response in transfer starts a link reset.
// - A UA or unsolicited F=1 response in transfer may start a link reset.
// - Answers to commands are never held back longer than T2; the code only sets the late flag in status bit 5 when T2 runs out.
// - In LAP, SARM gets UA at once, zeroes V(R) and clears busy.
// - LAP outgoing reset sends SARM with T1; UA zeroes V(S); N2 tries bound it.
// - Awaiting UA to SARM, responses and I command N(R) are ignored.
// - A CMDR response starts the SARM reset of the outgoing direction.
// - After CMDR only SARM or DISC clear; other commands resend CMDR.
package link_recovery_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned T1_MS = 3000;
    localparam int unsigned T2_MS = 1000;
    localparam int unsigned T1_CYCLES = T1_MS * (CLK_HZ / 1000);
    localparam int unsigned T2_CYCLES = T2_MS * (CLK_HZ / 1000);
    localparam logic [7:0] N2_RESET = 8'h0a;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int unsigned CTRL_LAP_BIT = 0;
    localparam int unsigned STATUS_T2_LATE_BIT = 5;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_N2 = 3'h1;
    localparam logic [2:0] REG_STATUS = 3'h2;
    localparam logic [2:0] REG_SEQ = 3'h3;
    localparam logic [2:0] REG_COUNT = 3'h4;
    localparam int unsigned FRMR_CR_BIT = 12;

    typedef enum logic [3:0] {
        K_I, K_RR, K_RNR, K_REJ, K_SABM, K_SARM, K_DISC, K_UA, K_DM, K_FRMR, K_CMDR, K_UNKNOWN
    } frame_kind_t;

    typedef enum logic [2:0] {
        ST_DISC, ST_INFO, ST_SARM_WAIT, ST_SABM_WAIT, ST_FRMR, ST_CMDR
    } link_state_t;

    typedef struct packed {
        frame_kind_t kind;
        logic is_cmd;
        logic addr_a;
        logic pf;
        logic [2:0] nr;
        logic [7:0] ctrl;
        logic info_bad;
    } rx_frame_t;

    typedef struct packed {
        frame_kind_t kind;
        logic is_cmd;
        logic pf;
        logic [2:0] nr;
        logic [19:0] info;
    } tx_frame_t;

    function automatic logic in_range(input logic [2:0] nr, input logic [2:0] lo, input logic [2:0] hi);
        logic [2:0] d_nr;
        logic [2:0] d_hi;
        d_nr = nr - lo;
        d_hi = hi - lo;
        return d_nr <= d_hi;
    endfunction : in_range
endpackage : link_recovery_pkg

/* File: rtl/link_timer.sv */
// Retriggerable down-counting timer with a one-cycle expiry pulse
`timescale 1ns/100ps
module link_timer #(
    parameter int unsigned COUNT = 1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic start,
    input wire logic stop,
    output logic expire,
    output logic running
);
    localparam logic [31:0] LOAD = 32'(COUNT - 1);
    logic [31:0] count;
    wire done = running && count == 32'h0;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count <= 32'h0;
            running <= 1'b0;
            expire <= 1'b0;
        end else begin
            expire <= done && !start && !stop;
            if (start) begin
                count <= LOAD;
                running <= 1'b1;
            end else if (stop || done) begin
                running <= 1'b0;
            end else if (running) begin
                count <= count - 32'h1;
            end
        end
    end
endmodule : link_timer

/* File: rtl/link_recovery.sv */
// Link-level recovery and reset control for the network side of the link
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/100ps
module link_recovery #(
    parameter int unsigned T1_COUNT = link_recovery_pkg::T1_CYCLES,
    parameter int unsigned T2_COUNT = link_recovery_pkg::T2_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic rx_valid,
    input link_recovery_pkg::rx_frame_t rx_frame,
    input wire logic rx_i_accept,
    input wire logic tx_i_sent,
    input wire logic busy_set,
    output link_recovery_pkg::tx_frame_t tx_frame,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [2:0] vs,
    output logic [2:0] vr,
    output logic busy,
    output logic recovery,
    output logic link_up,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    import link_recovery_pkg::*;

    link_state_t state, next_state;
    logic [7:0] ctrl, n2, cnt, next_cnt;
    logic [2:0] x, last_nr, next_vs, next_vr, next_x, next_last_nr;
    logic next_recovery, next_busy, t1_pend, t2_late;
    logic resp_pend, cmd_pend, resp_set, cmd_set, rst_go, t1_start, t1_stop, cap_info;
    tx_frame_t resp_frame, cmd_frame, resp_next, cmd_next;
    logic [19:0] frmr_info;
    logic t1_expire, t1_running, t2_expire;

    wire lap = ctrl[CTRL_LAP_BIT];
    wire rx_cmd = rx_frame.is_cmd;
    wire frame_kind_t kind = rx_frame.kind;
    wire is_s = kind == K_RR || kind == K_RNR || kind == K_REJ;
    wire has_nr = is_s || kind == K_I;
    wire nr_ok = recovery ? in_range(rx_frame.nr, vs, x) : in_range(rx_frame.nr, last_nr, vs);
    wire unknown = kind == K_UNKNOWN || (lap && kind == K_SABM) || (!lap && (kind == K_SARM || kind == K_CMDR));
    wire nr_bad = has_nr && !nr_ok;
    wire bad = unknown || rx_frame.info_bad || nr_bad;
    wire advance = rx_frame.nr != last_nr;
    wire cnt_hit = 8'(cnt + 8'h01) == n2;
    wire t1_serve = t1_pend && !rx_valid;
    wire resp_take = resp_pend && tx_ready;
    wire cmd_take = cmd_pend && !resp_pend && tx_ready;
    wire sabm_rx = rx_valid && rx_cmd && kind == K_SABM && !lap;
    wire sarm_rx = rx_valid && rx_cmd && kind == K_SARM && lap;
    wire disc_rx = rx_valid && rx_cmd && kind == K_DISC;
    wire [19:0] frmr_build = {nr_bad, 1'b0, rx_frame.info_bad, unknown, vr, rx_frame.addr_a, vs, 1'b0,
        rx_frame.ctrl};
    wire [7:0] status_word = {2'h0, t2_late, busy, recovery, state};

    // Responses go out ahead of commands so the T2 bound depends only on the transmitter
    assign tx_valid = resp_pend || cmd_pend;
    assign tx_frame = resp_pend ? resp_frame : cmd_frame;
    assign link_up = state != ST_DISC;

    link_timer #(.COUNT(T1_COUNT)) t1_timer (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .start(t1_start),
        .stop(t1_stop),
        .expire(t1_expire),
        .running(t1_running)
    );

    link_timer #(.COUNT(T2_COUNT)) t2_timer (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .start(resp_set && !resp_pend),
        .stop(resp_take),
        .expire(t2_expire),
        .running()
    );

    always_comb begin
        next_state = state;
        next_recovery = recovery;
        next_vs = (state == ST_INFO && tx_i_sent) ? 3'(vs + 3'h1) : vs;
        next_vr = (rx_i_accept && !busy) ? 3'(vr + 3'h1) : vr;
        next_x = x;
        next_last_nr = last_nr;
        next_cnt = cnt;
        next_busy = busy || busy_set;
        resp_set = 1'b0;
        cmd_set = 1'b0;
        rst_go = 1'b0;
        cap_info = 1'b0;
        t1_start = state == ST_INFO && tx_i_sent && !t1_running;
        t1_stop = 1'b0;
        resp_next = '{kind: K_UA, is_cmd: 1'b0, pf: rx_frame.pf, nr: vr, info: frmr_info};
        cmd_next = '{kind: K_I, is_cmd: 1'b1, pf: 1'b1, nr: vr, info: 20'h0};
        if (sabm_rx) begin
            resp_set = 1'b1;
            next_vs = 3'h0;
            next_vr = 3'h0;
            next_last_nr = 3'h0;
            next_busy = 1'b0;
            next_recovery = 1'b0;
            next_cnt = 8'h00;
            next_state = ST_INFO;
            t1_stop = 1'b1;
        end else if (disc_rx) begin
            resp_set = 1'b1;
            next_state = ST_DISC;
            next_recovery = 1'b0;
            t1_stop = 1'b1;
        end else if (sarm_rx) begin
            resp_set = 1'b1;
            next_vr = 3'h0;
            next_busy = 1'b0;
            if (state == ST_CMDR || state == ST_DISC) begin
                next_state = ST_INFO;
            end
        end else if (rx_valid) begin
            unique case (state)
                ST_DISC: begin
                    if (rx_cmd) begin
                        resp_set = 1'b1;
                        resp_next.kind = K_DM;
                    end
                end
                ST_SARM_WAIT: begin
                    // Anything but the UA, including I command N(R), is left alone here
                    if (!rx_cmd && kind == K_UA) begin
                        next_vs = 3'h0;
                        next_last_nr = 3'h0;
                        next_cnt = 8'h00;
                        next_state = ST_INFO;
                        t1_stop = 1'b1;
                    end
                end
                ST_SABM_WAIT: begin
                    if (!rx_cmd && kind == K_UA) begin
                        next_vs = 3'h0;
                        next_vr = 3'h0;
                        next_last_nr = 3'h0;
                        next_cnt = 8'h00;
                        next_state = ST_INFO;
                        t1_stop = 1'b1;
                    end else if (!rx_cmd && kind == K_DM) begin
                        next_state = ST_DISC;
                        t1_stop = 1'b1;
                    end
                end
                ST_FRMR: begin
                    if (!rx_cmd && kind == K_DM) begin
                        next_state = ST_DISC;
                        t1_stop = 1'b1;
                    end else if (rx_cmd) begin
                        resp_set = 1'b1;
                        resp_next.kind = K_FRMR;
                    end
                end
                ST_CMDR: begin
                    if (rx_cmd) begin
                        resp_set = 1'b1;
                        resp_next.kind = K_CMDR;
                    end
                end
                ST_INFO: begin
                    if (bad) begin
                        if (!lap) begin
                            resp_set = 1'b1;
                            resp_next.kind = K_FRMR;
                            resp_next.info = frmr_build;
                            cap_info = 1'b1;
                            next_state = ST_FRMR;
                            next_recovery = 1'b0;
                            next_cnt = 8'h01;
                            t1_start = 1'b1;
                        end else if (rx_cmd) begin
                            resp_set = 1'b1;
                            resp_next.kind = K_CMDR;
                            resp_next.info = frmr_build;
                            cap_info = 1'b1;
                            next_state = ST_CMDR;
                        end else begin
                            rst_go = 1'b1;
                        end
                    end else if (!rx_cmd && !lap && (kind == K_DM || kind == K_FRMR)) begin
                        rst_go = 1'b1;
                    end else if (!rx_cmd && lap && kind == K_CMDR) begin
                        rst_go = 1'b1;
                    end else if (!rx_cmd && !lap && (kind == K_UA || (rx_frame.pf && !recovery))) begin
                        rst_go = 1'b1;
                    end else if (!rx_cmd && kind == K_UA) begin
                        next_cnt = 8'h00;
                    end else if (has_nr) begin
                        next_last_nr = rx_frame.nr;
                        if (kind == K_RNR || advance) begin
                            next_cnt = 8'h00;
                        end
                        if (recovery && is_s) begin
                            next_vs = rx_frame.nr;
                            if (rx_frame.pf && !rx_cmd) begin
                                next_recovery = 1'b0;
                            end
                        end else if (kind == K_REJ) begin
                            next_vs = rx_frame.nr;
                        end
                        if (advance && !recovery) begin
                            t1_start = rx_frame.nr != vs;
                            t1_stop = rx_frame.nr == vs;
                        end
                    end
                end
                default: begin
                end
            endcase
        end else if (t1_serve) begin
            next_cnt = 8'(cnt + 8'h01);
            t1_start = 1'b1;
            unique case (state)
                ST_INFO: begin
                    if (cnt_hit) begin
                        rst_go = 1'b1;
                    end else begin
                        next_recovery = 1'b1;
                        next_x = vs;
                        next_vs = last_nr;
                        cmd_set = 1'b1;
                        cmd_next.nr = last_nr;
                    end
                end
                ST_SARM_WAIT, ST_SABM_WAIT: begin
                    if (cnt_hit) begin
                        resp_set = 1'b1;
                        resp_next.kind = K_DM;
                        resp_next.pf = 1'b0;
                        next_state = ST_DISC;
                        t1_start = 1'b0;
                        t1_stop = 1'b1;
                    end else begin
                        cmd_set = 1'b1;
                        cmd_next.kind = state == ST_SARM_WAIT ? K_SARM : K_SABM;
                    end
                end
                ST_FRMR: begin
                    if (cnt_hit) begin
                        next_state = ST_SABM_WAIT;
                        next_cnt = 8'h01;
                        cmd_set = 1'b1;
                        cmd_next.kind = K_SABM;
                    end else begin
                        resp_set = 1'b1;
                        resp_next.kind = K_FRMR;
                        resp_next.pf = 1'b0;
                    end
                end
                default: begin
                    t1_start = 1'b0;
                    t1_stop = 1'b1;
                end
            endcase
        end
        if (rst_go) begin
            next_state = lap ? ST_SARM_WAIT : ST_SABM_WAIT;
            next_recovery = 1'b0;
            next_cnt = 8'h01;
            cmd_set = 1'b1;
            cmd_next.kind = lap ? K_SARM : K_SABM;
            t1_start = 1'b1;
            t1_stop = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_DISC;
            recovery <= 1'b0;
            vs <= 3'h0;
            vr <= 3'h0;
            x <= 3'h0;
            last_nr <= 3'h0;
            cnt <= 8'h00;
            busy <= 1'b0;
            frmr_info <= 20'h0;
        end else begin
            state <= next_state;
            recovery <= next_recovery;
            vs <= next_vs;
            vr <= next_vr;
            x <= next_x;
            last_nr <= next_last_nr;
            cnt <= next_cnt;
            busy <= next_busy;
            if (cap_info) begin
                frmr_info <= frmr_build;
            end
        end
    end

    // A new request in the cycle a slot drains refills it rather than being lost
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            resp_pend <= 1'b0;
            cmd_pend <= 1'b0;
            resp_frame <= '0;
            cmd_frame <= '0;
            t1_pend <= 1'b0;
            t2_late <= 1'b0;
        end else begin
            resp_pend <= resp_set || (resp_pend && !resp_take);
            cmd_pend <= cmd_set || (cmd_pend && !cmd_take);
            t1_pend <= t1_expire || (t1_pend && rx_valid);
            t2_late <= t2_expire || (t2_late && !(reg_wr && reg_addr == REG_STATUS
                && reg_wdata[STATUS_T2_LATE_BIT]));
            if (resp_set) begin
                resp_frame <= resp_next;
            end
            if (cmd_set) begin
                cmd_frame <= cmd_next;
            end
        end
    end

    wire [7:0] rd_mux = reg_addr == REG_CTRL ? ctrl
        : reg_addr == REG_N2 ? n2
        : reg_addr == REG_STATUS ? status_word
        : reg_addr == REG_SEQ ? {2'h0, vr, vs}
        : reg_addr == REG_COUNT ? cnt : 8'h00;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= CTRL_RESET;
            n2 <= N2_RESET;
            reg_rdata <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == REG_CTRL) begin
                ctrl <= reg_wdata;
            end
            if (reg_wr && reg_addr == REG_N2) begin
                n2 <= reg_wdata;
            end
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_sabm_ua_reset: assert property (sabm_rx |=> resp_pend && resp_frame.kind == K_UA && vs == 3'h0
        && vr == 3'h0 && !busy) else $error("SABM not answered by UA with zeroed state");
    a_ack_clears_count: assert property (rx_valid && !rx_cmd && state == ST_INFO && !bad && has_nr
        && advance && !recovery && (lap || !rx_frame.pf) |=> cnt == 8'h00) else $error("Count not cleared");
    a_t1_enters_recovery: assert property (t1_serve && state == ST_INFO && !cnt_hit |=> recovery
        && vs == $past(last_nr) && x == $past(vs) && cnt == 8'($past(cnt) + 8'h01) && cmd_pend)
        else $error("T1 expiry did not enter recovery");
    a_n2_starts_reset: assert property (t1_serve && state == ST_INFO && cnt_hit |=>
        (state == ST_SABM_WAIT || state == ST_SARM_WAIT) && cmd_pend) else $error("N2 reached without reset");
    a_frmr_same_info: assert property (state == ST_FRMR && rx_valid && rx_cmd && !sabm_rx && !disc_rx
        |=> resp_frame.kind == K_FRMR && resp_frame.info == frmr_info) else $error("FRMR resent with other info");
    a_frmr_addr_bit: assert property (state == ST_INFO && rx_valid && bad && !lap && !sabm_rx && !disc_rx
        |=> state == ST_FRMR && frmr_info[FRMR_CR_BIT] == $past(rx_frame.addr_a)) else $error("FRMR bit 13 wrong");
    a_sarm_wait_ignore: assert property (state == ST_SARM_WAIT && rx_valid && !rx_cmd && kind != K_UA
        |=> state == ST_SARM_WAIT && vs == $past(vs)) else $error("Response acted on while awaiting UA");
    a_recovery_clear: assert property (recovery && state == ST_INFO && rx_valid && is_s && !rx_cmd
        && rx_frame.pf && !bad |=> !recovery && vs == $past(rx_frame.nr)) else $error("Recovery not cleared");
    a_cmdr_resend: assert property (state == ST_CMDR && rx_valid && rx_cmd && !sarm_rx && !disc_rx
        |=> state == ST_CMDR ##0 resp_pend && resp_frame.kind == K_CMDR) else $error("CMDR not resent");
endmodule : link_recovery

/* File: verification/far_end_model.sv */
// Far-end receiver model that takes frames sent by the block
`timescale 1ns/100ps
module far_end_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic tx_valid,
    input link_recovery_pkg::tx_frame_t tx_frame,
    input wire logic stall,
    output logic tx_ready,
    output link_recovery_pkg::tx_frame_t got,
    output int n_got
);
    import link_recovery_pkg::*;
    // A slow far end holds ready low; past T2 it breaks the answer bound on purpose to raise the late flag
    assign tx_ready = !stall;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            got <= '0;
            n_got <= 0;
        end else if (tx_valid && tx_ready) begin
            got <= tx_frame;
            n_got <= n_got + 1;
        end
    end
endmodule : far_end_model

/* File: verification/link_recovery_and_reset_test.sv */
// Self-checking bench for the link recovery block
`timescale 1ns/100ps
module link_recovery_and_reset_test;
    import link_recovery_pkg::*;
    logic clk_sys = 0, rst_b = 0, rx_valid = 0, rx_i_accept = 0, tx_i_sent = 0, busy_set = 0;
    logic tx_valid, tx_ready, busy, recovery, link_up, reg_wr = 0, reg_rd = 0, stall = 0;
    logic [2:0] vs, vr, reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata;
    logic [19:0] info;
    rx_frame_t rx_frame = '0;
    tx_frame_t tx_frame, got;
    int n_got, num_errors = 0, n_compared = 0, k;
    link_recovery #(.T1_COUNT(200), .T2_COUNT(50)) i_link_recovery (.clk_sys(clk_sys), .rst_b(rst_b),
        .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_i_accept(rx_i_accept), .tx_i_sent(tx_i_sent),
        .busy_set(busy_set), .tx_frame(tx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready), .vs(vs), .vr(vr),
        .busy(busy), .recovery(recovery), .link_up(link_up), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    far_end_model i_far_end_model (.clk_sys(clk_sys), .rst_b(rst_b), .tx_valid(tx_valid),
        .tx_frame(tx_frame), .stall(stall), .tx_ready(tx_ready), .got(got), .n_got(n_got));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rx(input frame_kind_t f, input logic c, input logic a, input logic p, input logic [2:0] n);
        @(posedge clk_sys);
        rx_valid <= 1;
        rx_frame <= '{f, c, a, p, n, 8'h00, 1'b0};
        @(posedge clk_sys);
        rx_valid <= 0;
    endtask : rx
    task automatic pulse(input int w);
        @(posedge clk_sys);
        tx_i_sent <= (w == 0);
        rx_i_accept <= (w == 1);
        busy_set <= (w == 2);
        @(posedge clk_sys);
        {tx_i_sent, rx_i_accept, busy_set} <= 3'b000;
        #1;
    endtask : pulse
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= 2'b00;
        #1;
        if (!w) chk(reg_rdata, d);
    endtask : bus
    // Waits for the next frame of the given kind; other frames may pass first
    task automatic txw(input frame_kind_t f);
        int n0 = n_got;
        int t = 0;
        while (!(n_got != n0 && got.kind === f) && t < 800) begin
            @(posedge clk_sys);
            t++;
        end
        #1 chk(got.kind, f);
    endtask : txw
    task automatic end_of_test;
        $display("Comparisons %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        end_of_test();
    end
    initial begin
        void'($urandom(63681));
        repeat (16) @(posedge clk_sys);
        rst_b <= 1;
        bus(0, REG_N2, N2_RESET);
        bus(0, 3'h5, 8'h00);
        bus(1, REG_N2, 8'h03);
        bus(0, REG_N2, 8'h03);
        stall <= 1;
        rx(K_SABM, 1, 0, 1, 0);
        repeat (10) @(posedge clk_sys);
        #1 chk(tx_valid, 1);
        repeat (50) @(posedge clk_sys);
        bus(0, REG_STATUS, 8'h21);
        bus(1, REG_STATUS, 8'h20);
        bus(0, REG_STATUS, 8'h01);
        stall <= 0;
        txw(K_UA);
        chk({got.is_cmd, got.pf}, 2'b01);
        chk({vs, vr, link_up}, 7'h01);
        pulse(1);
        pulse(2);
        chk({busy, vr}, 4'h9);
        rx(K_SABM, 1, 0, 0, 0);
        txw(K_UA);
        chk({busy, vs, vr}, 7'h00);
        k = 1 + $urandom % 3;
        repeat (k) pulse(0);
        chk(vs, k[2:0]);
        txw(K_I);
        chk({recovery, vs, got.pf, got.is_cmd, got.nr}, 9'h118);
        bus(0, REG_COUNT, 8'h01);
        rx(K_RR, 0, 1, 0, 1);
        #1 chk(recovery, 1);
        rx(K_RR, 0, 1, 1, k[2:0]);
        #1 chk({recovery, vs}, {1'b0, k[2:0]});
        bus(0, REG_COUNT, 8'h00);
        pulse(0);
        repeat (2) txw(K_I);
        txw(K_SABM);
        bus(0, REG_STATUS, 8'h03);
        rx(K_UA, 0, 1, 1, 0);
        bus(0, REG_STATUS, 8'h01);
        for (int a = 0; a < 2; a++) begin
            rx(K_UNKNOWN, 1, a[0], 0, 0);
            txw(K_FRMR);
            info = got.info;
            chk(info[FRMR_CR_BIT], a[0]);
            chk(info, {4'h1, 3'h0, a[0], 12'h000});
            bus(0, REG_STATUS, 8'h04);
            rx(K_RR, 1, 0, 0, 0);
            txw(K_FRMR);
            chk(got.info, info);
            rx(K_SABM, 1, 0, 0, 0);
            txw(K_UA);
        end
        rx(K_DM, 0, 1, 0, 0);
        txw(K_SABM);
        rx(K_UA, 0, 1, 1, 0);
        bus(0, REG_STATUS, 8'h01);
        bus(1, REG_CTRL, 8'h01);
        pulse(1);
        rx(K_SARM, 1, 0, 0, 0);
        txw(K_UA);
        chk(vr, 0);
        rx(K_UNKNOWN, 1, 0, 0, 0);
        txw(K_CMDR);
        rx(K_RR, 1, 0, 0, 0);
        txw(K_CMDR);
        rx(K_SARM, 1, 0, 0, 0);
        txw(K_UA);
        bus(0, REG_STATUS, 8'h01);
        pulse(0);
        rx(K_CMDR, 0, 1, 0, 0);
        txw(K_SARM);
        rx(K_RR, 0, 1, 1, 5);
        bus(0, REG_STATUS, 8'h02);
        bus(0, REG_SEQ, 8'h01);
        rx(K_UA, 0, 1, 1, 0);
        bus(0, REG_STATUS, 8'h01);
        chk(vs, 0);
        end_of_test();
    end
endmodule : link_recovery_and_reset_test
